// file: psq_por_sequencer.sv
// power-on reset sequencer with serial status port
`timescale 1ns/1ps
`default_nettype none
`include "psq_cfg.svh"

module psq_por_sequencer
  import psq_pkg::*;
#(
  parameter logic [31:0] CHIP_ID = 32'h0000_0A5A  // arbitrary value
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // board pins
  input  wire logic        external_cold_reset_in_b_i,
  input  wire logic        core_pll_locked_i,
  input  wire logic        io_ready_i,
  input  wire logic [1:0]  multichip_id_i,
  input  wire logic [3:0]  system_configuration_in_i,
  input  wire logic [7:0]  processing_element_good_i,
  // serial configuration port
  input  wire logic        spi_clk_i,
  input  wire logic        spi_en_i,
  input  wire logic        spi_si_i,
  output logic             spi_so_o,
  // status and control outputs
  output logic             attention_o,
  output logic             pll_lock_indicator_o,
  output logic             sequence_done_o,
  output logic [31:0]      config_ring_o
);

  psq_st_t     st_reg;
  psq_st_t     st_next;
  psq_pins_t   pins;
  logic [11:0] pins_agree;
  logic        clk_rise;
  logic        clk_fall;
  logic        port_open;
  logic        cmd_ok;
  logic [15:0] addr;
  logic [1:0]  cmd;
  logic        rd_ok;
  logic [15:0] rd_addr;
  logic [31:0] wdata;
  logic [31:0] spi_status;
  logic [31:0] por_status;
  logic [31:0] rdata;

  assign pins = '{spi_clk:    spi_clk_i,
                  spi_en:     spi_en_i,
                  spi_si:     spi_si_i,
                  cold_rst_b: external_cold_reset_in_b_i,
                  pll_lock:   core_pll_locked_i,
                  io_ready:   io_ready_i,
                  mc_id:      multichip_id_i,
                  sys_cfg:    system_configuration_in_i};

  // a pin change counts once the second and third stages agree
  assign pins_agree = st_reg.s2 ~^ st_reg.s3;

  assign clk_rise = pins_agree[11] & st_reg.s3.spi_clk & ~st_reg.filt.spi_clk;
  assign clk_fall = pins_agree[11] & ~st_reg.s3.spi_clk & st_reg.filt.spi_clk;

  // serial port stays deaf until internal init of phase one is over
  assign port_open = (st_reg.state != PSQ_PH1);

  // shift register holds bits msb first: command, address, data
  assign cmd_ok = (st_reg.shin[55:52] == `PSQ_CHIP_SEL) &&
                  (st_reg.shin[51:50] == st_reg.filt.mc_id);
  assign cmd    = st_reg.shin[49:48];
  assign addr   = st_reg.shin[47:32];
  assign wdata  = st_reg.shin[31:0];

  // at the read turn-around only command and address are in, so they sit in the low bits
  assign rd_ok   = (st_reg.shin[23:20] == `PSQ_CHIP_SEL) &&
                   (st_reg.shin[19:18] == st_reg.filt.mc_id) &&
                   (st_reg.shin[17:16] == `PSQ_CMD_RD);
  assign rd_addr = st_reg.shin[15:0];

  always_comb begin
    spi_status                         = 32'h0000_0000;
    spi_status[`PSQ_SPS_ATTN]          = st_reg.attn;
    // software and thermal causes stay zero: no software, thermal off
    spi_status[30:27]                  = 4'h0;
    spi_status[25]                     = 1'b0;
    spi_status[24]                     = 1'b0;
    if (st_reg.state == PSQ_RING_REQ) begin
      spi_status[`PSQ_SPS_REQ_HI:`PSQ_SPS_REQ_LO] = `PSQ_SPS_REQ_RING;
    end
    if (st_reg.io_ok) begin
      spi_status[`PSQ_SPS_IO_A] = 1'b1;
      spi_status[`PSQ_SPS_IO_B] = 1'b1;
      spi_status[`PSQ_SPS_IO_C] = 1'b1;
      spi_status[`PSQ_SPS_IO_D] = 1'b1;
    end
    spi_status[`PSQ_SPS_RST_INV]       = ~st_reg.filt.cold_rst_b;
    spi_status[1:0]                    = `PSQ_SPS_CONST;
  end

  always_comb begin
    por_status                   = 32'h0000_0000;
    por_status[`PSQ_POR_TMO]     = st_reg.tmo;
    por_status[`PSQ_POR_CFG_BAD] = |st_reg.filt.sys_cfg;
    por_status[`PSQ_POR_ERR]     = st_reg.tmo | st_reg.ring_fail |
                                   (|st_reg.filt.sys_cfg);
    por_status[`PSQ_POR_CAL]     = st_reg.cal_done;
    por_status[`PSQ_POR_RING]    = st_reg.ring_ack;
    por_status[`PSQ_POR_DONE]    = st_reg.done;
    por_status[`PSQ_POR_IO_OK]   = st_reg.io_ok;
    por_status[`PSQ_POR_P2_OK]   = st_reg.p2_ok;
  end

  always_comb begin
    case (rd_addr)
      `PSQ_ADR_CHIP_ID:   rdata = CHIP_ID;
      `PSQ_ADR_SPI_STAT:  rdata = spi_status;
      `PSQ_ADR_POR_STAT:  rdata = por_status;
      // availability data for the controller to merge into the ring
      `PSQ_ADR_PART_GOOD: rdata = {24'h00_0000, processing_element_good_i};
      default:            rdata = 32'h0000_0000;
    endcase
  end

  always_comb begin
    st_next      = st_reg;
    st_next.s1   = pins;
    st_next.s2   = st_reg.s1;
    st_next.s3   = st_reg.s2;
    st_next.filt = psq_pins_t'((pins_agree & st_reg.s3) | (~pins_agree & st_reg.filt));

    st_next.pll_ind = st_reg.filt.pll_lock;

    // serial port: one bit per rising edge, output moves on falling edge
    if (!st_reg.filt.spi_en || !port_open) begin
      st_next.bit_cnt = 6'd0;
      st_next.shout   = 32'h0000_0000;
      st_next.so      = 1'b0;
    end else begin
      if (clk_rise && st_reg.bit_cnt != `PSQ_DATA_END) begin
        st_next.shin    = {st_reg.shin[54:0], st_reg.filt.spi_si};
        st_next.bit_cnt = st_reg.bit_cnt + 6'd1;
      end
      if (clk_fall) begin
        st_next.so    = st_reg.shout[31];
        st_next.shout = {st_reg.shout[30:0], 1'b0};
      end
      // read data is loaded once the address is in
      if (st_reg.bit_cnt == `PSQ_ADDR_END && clk_fall && rd_ok) begin
        st_next.so    = rdata[31];
        st_next.shout = {rdata[30:0], 1'b0};
      end
    end

    case (st_reg.state)
      PSQ_PH1: begin
        // internal init waits for lock, then runs its fixed count
        if (st_reg.filt.pll_lock) begin
          if (st_reg.cnt == 12'(`PSQ_PH1_INIT_CYC - 1)) begin
            st_next.state = PSQ_WAIT_RST;
            st_next.cnt   = 12'h000;
          end else begin
            st_next.cnt = st_reg.cnt + 12'h001;
          end
        end
      end
      PSQ_WAIT_RST: begin
        if (st_reg.filt.cold_rst_b) begin
          st_next.state = PSQ_RING_REQ;
          st_next.attn  = 1'b1;
          st_next.p2_ok = 1'b1;
        end
      end
      PSQ_RING_REQ: begin
        // ring load is external: waits with no timeout
        if (st_reg.bit_cnt == `PSQ_DATA_END && clk_fall && cmd_ok &&
            cmd == `PSQ_CMD_WR && addr == `PSQ_ADR_CFG_RING) begin
          st_next.bit_cnt = 6'd0;
          if (wdata[`PSQ_RING_START]) begin
            st_next.ring     = wdata;
            st_next.ring_ack = 1'b1;
            st_next.attn     = 1'b0;
            st_next.state    = PSQ_IO_INIT;
            st_next.cnt      = 12'h000;
          end else begin
            st_next.ring_fail = 1'b1;
          end
        end
      end
      PSQ_IO_INIT: begin
        // io interface reset is an internal step, so it is timed
        if (st_reg.filt.io_ready) begin
          st_next.io_ok = 1'b1;
          st_next.state = PSQ_CAL_WAIT;
        end else if (st_reg.cnt == 12'(`PSQ_IO_TMO_CYC - 1)) begin
          st_next.tmo = 1'b1;
        end else begin
          st_next.cnt = st_reg.cnt + 12'h001;
        end
      end
      PSQ_CAL_WAIT: begin
        // calibration wait is external, no timeout
        if (st_reg.bit_cnt == `PSQ_DATA_END && clk_fall && cmd_ok &&
            cmd == `PSQ_CMD_WR && addr == `PSQ_ADR_SPI_STAT &&
            wdata[`PSQ_WSS_CAL_DONE]) begin
          st_next.bit_cnt  = 6'd0;
          st_next.cal_done = 1'b1;
          st_next.done     = 1'b1;
          st_next.state    = PSQ_DONE;
        end
      end
      PSQ_DONE: begin
        st_next.state = PSQ_DONE;
      end
      default: begin
        st_next.state = PSQ_PH1;
      end
    endcase

    // a completed write that no state took is just dropped
    if (st_reg.bit_cnt == `PSQ_DATA_END && clk_fall && st_next.bit_cnt == `PSQ_DATA_END) begin
      st_next.bit_cnt = `PSQ_DATA_END;
    end

    // cold reset asserted again restarts the whole sequence
    if (!st_reg.filt.cold_rst_b && st_reg.state != PSQ_PH1 && st_reg.state != PSQ_WAIT_RST) begin
      st_next.state     = PSQ_PH1;
      st_next.cnt       = 12'h000;
      st_next.attn      = 1'b0;
      st_next.ring_ack  = 1'b0;
      st_next.ring_fail = 1'b0;
      st_next.tmo       = 1'b0;
      st_next.io_ok     = 1'b0;
      st_next.cal_done  = 1'b0;
      st_next.done      = 1'b0;
      st_next.p2_ok     = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      st_reg       <= '0;
      st_reg.state <= PSQ_PH1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign spi_so_o             = st_reg.so;
  assign attention_o          = st_reg.attn;
  assign pll_lock_indicator_o = st_reg.pll_ind;
  assign sequence_done_o      = st_reg.done;
  assign config_ring_o        = st_reg.ring;

endmodule
`default_nettype wire

// file: psq_cfg.svh
// constants of the reset sequencer: bit positions, addresses, timing
`ifndef PSQ_CFG_SVH
`define PSQ_CFG_SVH

`define PSQ_CLK_MHZ        40
`define PSQ_PH1_INIT_NS    10000
`define PSQ_PH1_INIT_CYC   ((`PSQ_PH1_INIT_NS * `PSQ_CLK_MHZ + 999) / 1000)
`define PSQ_IO_TMO_NS      100000
`define PSQ_IO_TMO_CYC     ((`PSQ_IO_TMO_NS * `PSQ_CLK_MHZ) / 1000)

`define PSQ_CHIP_SEL       4'h1
`define PSQ_CMD_RD         2'h0
`define PSQ_CMD_WR         2'h1
`define PSQ_CMD_END        6'd8
`define PSQ_ADDR_END       6'd24
`define PSQ_DATA_END       6'd56

`define PSQ_ADR_CHIP_ID    16'h0000
`define PSQ_ADR_SPI_STAT   16'h0001
`define PSQ_ADR_POR_STAT   16'h0002
`define PSQ_ADR_PART_GOOD  16'h0003
`define PSQ_ADR_CFG_RING   16'h0004

// bit n counted from the msb is vector index 31-n
`define PSQ_SPS_ATTN       31
`define PSQ_SPS_IO_A       23
`define PSQ_SPS_IO_B       22
`define PSQ_SPS_REQ_HI     21
`define PSQ_SPS_REQ_LO     20
`define PSQ_SPS_RST_INV    6
`define PSQ_SPS_IO_C       3
`define PSQ_SPS_IO_D       2
`define PSQ_SPS_CONST      2'h1
`define PSQ_SPS_REQ_RING   2'h2
`define PSQ_WSS_CAL_DONE   23
`define PSQ_POR_ERR        31
`define PSQ_POR_TMO        30
`define PSQ_POR_CAL        22
`define PSQ_POR_RING       20
`define PSQ_POR_IO_OK      14
`define PSQ_POR_CFG_BAD    11
`define PSQ_POR_DONE       9
`define PSQ_POR_P2_OK      8
`define PSQ_RING_START     31

`endif

// file: psq_pkg.sv
// types of the reset sequencer
package psq_pkg;

  typedef enum logic [2:0] {
    PSQ_PH1,
    PSQ_WAIT_RST,
    PSQ_RING_REQ,
    PSQ_IO_INIT,
    PSQ_CAL_WAIT,
    PSQ_DONE
  } psq_state_t;

  typedef struct packed {
    logic       spi_clk;
    logic       spi_en;
    logic       spi_si;
    logic       cold_rst_b;
    logic       pll_lock;
    logic       io_ready;
    logic [1:0] mc_id;
    logic [3:0] sys_cfg;
  } psq_pins_t;

  typedef struct packed {
    psq_pins_t   s1;
    psq_pins_t   s2;
    psq_pins_t   s3;
    psq_pins_t   filt;
    psq_state_t  state;
    logic [11:0] cnt;
    logic [5:0]  bit_cnt;
    logic [55:0] shin;
    logic [31:0] shout;
    logic        so;
    logic        attn;
    logic        pll_ind;
    logic        ring_ack;
    logic        ring_fail;
    logic        tmo;
    logic        io_ok;
    logic        cal_done;
    logic        done;
    logic        p2_ok;
    logic [31:0] ring;
  } psq_st_t;

endpackage

// file: psq_spi_master.sv
// serial configuration master model standing in for the system controller
`timescale 1ns/1ps
`default_nettype none
module psq_spi_master (
  // clock
  input  wire logic mclk_i,
  // serial pins
  input  wire logic spi_so_i,
  output logic      spi_clk_o,
  output logic      spi_en_o,
  output logic      spi_si_o
);
  initial begin
    spi_clk_o = 1'b0;
    spi_en_o  = 1'b0;
    spi_si_o  = 1'b0;
  end
  // half period of ten mclk keeps the edge filter well clear
  task automatic hp;
    repeat (10) @(posedge mclk_i);
    #1;
  endtask
  // chip id 0001, multichip id 00, msb first, clock low outside frames but for one pulse with enable low after each
  task automatic xfer(input logic [1:0] cmd, input logic [15:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    logic [55:0] f;
    f = {4'h1, 2'h0, cmd, adr, wd};
    rd = 32'h0;
    for (int i = 55; i >= 0; i--) begin
      spi_en_o = 1'b1;
      spi_si_o = f[i];
      hp();
      if (i < 32) rd[i] = spi_so_i;
      spi_clk_o = 1'b1;
      hp();
      spi_clk_o = 1'b0;
    end
    hp();
    // one clock with enable low between frames, data line no longer valid
    spi_en_o = 1'b0;
    spi_si_o = ~spi_si_o;
    hp();
    spi_clk_o = 1'b1;
    hp();
    spi_clk_o = 1'b0;
    hp();
  endtask
endmodule
`default_nettype wire

// file: psq_props.sv
// port-level assertions of the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module psq_props (
  // clock and reset
  input wire logic        mclk_i,
  input wire logic        rst_b_i,
  // watched pins
  input wire logic        external_cold_reset_in_b_i,
  input wire logic        core_pll_locked_i,
  input wire logic        spi_so_o,
  input wire logic        attention_o,
  input wire logic        pll_lock_indicator_o,
  input wire logic        sequence_done_o,
  input wire logic [31:0] config_ring_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  logic [8:0] lk_reg;
  // counts settled lock time so a release after phase one init is recognised
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i || !pll_lock_indicator_o) lk_reg <= 9'h0;
    else if (lk_reg != 9'd480) lk_reg <= lk_reg + 9'h1;
  end
  sequence s_done_held;
    (sequence_done_o && external_cold_reset_in_b_i) [*6];
  endsequence
  a_lock_follow: assert property ($rose(core_pll_locked_i) |-> ##[1:8] pll_lock_indicator_o) else $error("lock indicator late");
  a_ph1_quiet: assert property (!pll_lock_indicator_o |-> !attention_o && !sequence_done_o) else $error("activity in phase one");
  a_ph1_so_idle: assert property (!pll_lock_indicator_o |-> !spi_so_o) else $error("serial out active in phase one");
  a_attn_needs_rst: assert property ($rose(attention_o) |-> external_cold_reset_in_b_i) else $error("attention under reset");
  a_attn_prompt: assert property ($rose(external_cold_reset_in_b_i) && lk_reg == 9'd480 |-> ##[1:12] attention_o) else $error("attention not raised");
  a_ack_start_bit: assert property ($fell(attention_o) |-> config_ring_o[31]) else $error("ring taken without start bit");
  a_ack_then_wait: assert property ($fell(attention_o) |-> !sequence_done_o) else $error("finished before calibration");
  a_done_no_attn: assert property (sequence_done_o |-> !attention_o) else $error("attention after completion");
  a_done_stays: assert property (s_done_held |=> sequence_done_o) else $error("completion flag dropped");
endmodule
bind psq_por_sequencer psq_props u_props (
  .mclk_i                     (mclk_i),
  .rst_b_i                    (rst_b_i),
  .external_cold_reset_in_b_i (external_cold_reset_in_b_i),
  .core_pll_locked_i          (core_pll_locked_i),
  .spi_so_o                   (spi_so_o),
  .attention_o                (attention_o),
  .pll_lock_indicator_o       (pll_lock_indicator_o),
  .sequence_done_o            (sequence_done_o),
  .config_ring_o              (config_ring_o)
);
`default_nettype wire

// file: psq_por_sequencer_tb.sv
// self-checking testbench of the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module psq_por_sequencer_tb
  import psq_pkg::*;
;
  localparam logic [31:0] CHIP_ID_EXP = 32'h0000_0C3C;  // arbitrary value
  logic mclk = 1'b0, rst_b = 1'b0, cold_b = 1'b0, lock = 1'b0, io_rdy = 1'b0;
  logic [3:0] sys_cfg = 4'h0;
  logic [7:0] peg = 8'hB6;
  logic [7:0] pg_seen;
  logic spi_clk, spi_en, spi_si, spi_so, attn, ind, done;
  logic [31:0] ring, d;
  int num_errors = 0, checked = 0, cyc = 0;
  always #12.5 mclk = ~mclk;
  psq_spi_master m (.mclk_i(mclk), .spi_so_i(spi_so), .spi_clk_o(spi_clk), .spi_en_o(spi_en), .spi_si_o(spi_si));
  psq_por_sequencer #(.CHIP_ID(CHIP_ID_EXP)) DUT (
    .mclk_i(mclk), .rst_b_i(rst_b), .external_cold_reset_in_b_i(cold_b), .core_pll_locked_i(lock),
    .io_ready_i(io_rdy), .multichip_id_i(2'h0), .system_configuration_in_i(sys_cfg),
    .processing_element_good_i(peg), .spi_clk_i(spi_clk), .spi_en_i(spi_en), .spi_si_i(spi_si),
    .spi_so_o(spi_so), .attention_o(attn), .pll_lock_indicator_o(ind), .sequence_done_o(done),
    .config_ring_o(ring));
  task automatic w(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [15:0] a);
    m.xfer(2'h0, a, 32'h0, d);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    logic [31:0] x;
    m.xfer(2'h1, a, v, x);
  endtask
  task automatic t_phase1;
    rd(16'h0001);
    chk("status in phase one", 32'h0, d);
    chk("lock indicator unlocked", 32'h0, {31'h0, ind});
    lock = 1'b1;
    w(10);
    chk("lock indicator locked", 32'h1, {31'h0, ind});
    $display("test t_phase1 done");
  endtask
  // release cold reset, then ring request status, id and partial good
  task automatic t_release(input logic [3:0] cfg);
    sys_cfg = cfg;
    w(500);
    cold_b = 1'b1;
    w(12);
    chk("attention after release", 32'h1, {31'h0, attn});
    rd(16'h0001);
    chk("status in ring wait", 32'h8020_0001, d);
    rd(16'h0000);
    chk("chip id", CHIP_ID_EXP, d);
    rd(16'h0002 + 16'h0001);
    chk("partial good", {24'h0, peg}, d);
    pg_seen = d[7:0];
    rd(16'h0001);
    chk("status still waiting", 32'h8020_0001, d);
  endtask
  task automatic t_clean;
    t_release(4'h0);
    wr(16'h0004, {1'b1, 23'h0, pg_seen});
    w(10);
    chk("attention after ack", 32'h0, {31'h0, attn});
    chk("ring word", {1'b1, 23'h0, peg}, ring);
    io_rdy = 1'b1;
    w(10);
    rd(16'h0001);
    chk("status io ready", 32'h00C0_000D, d);
    chk("not done before cal", 32'h0, {31'h0, done});
    wr(16'h0001, 32'h0080_0000);
    w(10);
    chk("done after cal", 32'h1, {31'h0, done});
    rd(16'h0002);
    chk("reset status clean", 32'h0050_4300, d);
    $display("test t_clean done");
  endtask
  // restart with a wrong configuration and a ring without start bit
  task automatic t_bad;
    cold_b = 1'b0;
    io_rdy = 1'b0;
    t_release(4'h1);
    wr(16'h0004, 32'h0000_00FF);
    w(20);
    chk("attention kept", 32'h1, {31'h0, attn});
    rd(16'h0002);
    chk("reset status faults", 32'h8000_0800, d & 32'h8010_0800);
    // good ring now, but io never reports ready: the internal io step must time out
    wr(16'h0004, {1'b1, 23'h0, pg_seen});
    w(4100);
    rd(16'h0002);
    chk("io step timeout", 32'hC000_0000, d & 32'hC000_0000);
    $display("test t_bad done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    w(16);
    rst_b = 1'b1;
    t_phase1();
    t_clean();
    t_bad();
    conclude();
  end
endmodule
`default_nettype wire
